// ### hdl/ocpu_core.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Memory accesses go to the space chosen by the space-select flag.
// - Both spaces hold 64K bytes, addressed by 16-bit addresses.
// - Direct mode takes the address from the instruction; immediates allowed.
// - Word accesses cover the address and the next higher byte.
// - Indirect mode uses a working-register pair as the address.
// - Post-increment accesses first, then increments the pair.
// - Pre-decrement decrements the pair first, then accesses.
// - Indexed modes add a short or long immediate offset to a pair.
// - Register-indexed mode adds two even-numbered pairs.
// - Bit test-and-set tests then sets a bit at a pair's address.
// - Wait stalls until interrupt; DMA is served, then waiting resumes.
// - Halt stops execution until the next system reset.
// - The flag register sits at location 231 with six flags.
// - Flag bit 0 selects the space; bit 1 is a free user bit.
// - Jump conditions use C, Z, S, V; shared meanings share a code.
// - Long pointer sets 16 working registers; short ones set 8 each.
// - Decrement a pair or a register and branch when nonzero.
// - Compare-jump branches on false or true, else post-increments.
// - Cross-space loads ignore the selection; four space combinations.
// - Arithmetic gives 8x8 multiply, 16/8 divide, stepped 32/16 divide.
// - Operation codes cover 87 instruction types.
// - Short index offsets are sign-extended bytes.
module ocpu_core
	import ocpu_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic [7:0] RF_ADDR,
	input wire logic RF_WE,
	input wire logic [7:0] RF_WDATA,
	output logic [7:0] RF_RDATA,
	input wire logic OP_VALID,
	input wire logic [OPC_W-1:0] OP_CODE,
	input wire logic [2:0] OP_MODE,
	input wire logic OP_WORD,
	input wire logic [3:0] OP_PA,
	input wire logic [3:0] OP_PB,
	input wire logic [15:0] OP_IMM,
	input wire logic IRQ_PIN,
	input wire logic DMA_REQ_PIN,
	input wire logic [15:0] MEM_RDATA,
	output logic [ADDR_W-1:0] MEM_ADDR,
	output logic [ADDR_W-1:0] MEM_ADDR_NEXT,
	output logic MEM_WORD,
	output logic MEM_PROG,
	output logic MEM_STB,
	output logic MEM_WE,
	output logic [15:0] MEM_WDATA,
	output logic [15:0] RESULT,
	output logic [7:0] FLAGS,
	output logic [7:0] RP_LOW,
	output logic [7:0] RP_HIGH,
	output logic BRANCH,
	output logic DMA_ACK,
	output logic BUSY,
	output logic HALTED,
	output logic WAITING,
	output logic ILLEGAL
);
	// ==============================
	// Helpers
	function automatic logic [7:0] wra(input logic [3:0] r,
		input logic [7:0] p0, input logic [7:0] p1);
		wra = r[3] ? {p1[7:3], r[2:0]} : {p0[7:3], r[2:0]};
	endfunction : wra

	function automatic logic [255:0][7:0] put_pair(
		input logic [255:0][7:0] rf, input logic [7:0] hi,
		input logic [7:0] lo, input logic [15:0] v);
		put_pair = rf;
		put_pair[hi] = v[15:8];
		put_pair[lo] = v[7:0];
	endfunction : put_pair

	function automatic logic cond_met(input logic [7:0] f,
		input logic [3:0] cc);
		logic b;
		case (cc[2:0])
		3'h1: b = f[FB_S] ^ f[FB_V];
		3'h2: b = f[FB_Z] | (f[FB_S] ^ f[FB_V]);
		3'h3: b = f[FB_C] | f[FB_Z];
		3'h4: b = f[FB_V];
		3'h5: b = f[FB_S];
		3'h6: b = f[FB_Z];
		3'h7: b = f[FB_C];
		default: b = 1'b0;
		endcase
		cond_met = b ^ cc[3];
	endfunction : cond_met

	ocpu_s_t s_q, s_d;
	logic acc;
	logic [7:0] ah_a, al_a, ah_b, al_b, wb_adr;
	logic [15:0] pair_a, pair_b, step;

	assign acc = CE && s_q.st == ST_IDLE && OP_VALID;
	assign ah_a = wra({OP_PA[3:1], 1'b0}, s_q.rp0, s_q.rp1);
	assign al_a = wra({OP_PA[3:1], 1'b1}, s_q.rp0, s_q.rp1);
	assign ah_b = wra({OP_PB[3:1], 1'b0}, s_q.rp0, s_q.rp1);
	assign al_b = wra({OP_PB[3:1], 1'b1}, s_q.rp0, s_q.rp1);
	assign wb_adr = wra(OP_PB, s_q.rp0, s_q.rp1);
	assign pair_a = {s_q.rf[ah_a], s_q.rf[al_a]};
	assign pair_b = {s_q.rf[ah_b], s_q.rf[al_b]};
	assign step = OP_WORD ? 16'h0002 : 16'h0001;

	// ==============================
	// Next-state logic
	always_comb begin
		logic [15:0] ea, q, pv;
		logic [32:0] sh;
		logic [7:0] wr;
		logic hit;
		ea = 16'h0000;
		q = 16'h0000;
		pv = 16'h0000;
		sh = 33'h000000000;
		wr = 8'h00;
		hit = 1'b0;
		s_d = s_q;
		s_d.irq_s1 = IRQ_PIN;
		s_d.irq_s2 = s_q.irq_s1;
		s_d.dma_s1 = DMA_REQ_PIN;
		s_d.dma_s2 = s_q.dma_s1;
		s_d.stb = 1'b0;
		s_d.we = 1'b0;
		s_d.branch = 1'b0;
		s_d.dma_ack = 1'b0;
		s_d.illegal = 1'b0;
		if (RF_WE) begin
			if (RF_ADDR == FLAG_REG_ADDR) begin
				s_d.flags = RF_WDATA;
			end else begin
				s_d.rf[RF_ADDR] = RF_WDATA;
			end
		end
		s_d.rdo = (RF_ADDR == FLAG_REG_ADDR) ? s_q.flags : s_q.rf[RF_ADDR];
		// Effective address; 16-bit sums wrap by width.
		case (OP_MODE)
		AM_DIRECT: ea = OP_IMM;
		AM_PREDEC: ea = pair_a - step;
		AM_SHORT: ea = pair_a + {{8{OP_IMM[7]}}, OP_IMM[7:0]};
		AM_LONG: ea = pair_a + OP_IMM;
		AM_REGIDX: ea = pair_a + pair_b;
		default: ea = pair_a;
		endcase
		wr = s_q.rf[wb_adr];
		case (s_q.st)
		ST_IDLE: begin
			if (OP_VALID) begin
				s_d.op = OP_CODE;
				s_d.addr = ea;
				s_d.addr_hi = ea + 16'h0001;
				s_d.word = OP_WORD;
				s_d.prog = ~s_q.flags[FB_DP];
				s_d.sv_a = OP_PA[3:1];
				s_d.bitn = OP_IMM[2:0];
				s_d.cmp = wr;
				case (OP_CODE)
				mem_read_op, mem_write_op: begin
					s_d.stb = 1'b1;
					s_d.we = OP_CODE == mem_write_op;
					s_d.wdata = OP_IMM;
					if (OP_CODE == mem_read_op) begin
						s_d.st = ST_READ;
					end
					if (OP_MODE == AM_POSTINC) begin
						s_d.rf = put_pair(s_d.rf, ah_a, al_a, pair_a + step);
					end
					if (OP_MODE == AM_PREDEC) begin
						s_d.rf = put_pair(s_d.rf, ah_a, al_a, ea);
					end
				end
				bit_test_set_op, compare_jump_false_op,
				compare_jump_true_op: begin
					s_d.addr = pair_a;
					s_d.addr_hi = pair_a + 16'h0001;
					s_d.word = 1'b0;
					s_d.stb = 1'b1;
					s_d.st = ST_READ;
				end
				load_prog_to_prog_op, load_data_to_prog_op,
				load_prog_to_data_op, load_data_to_data_op: begin
					s_d.addr = pair_b;
					s_d.addr_hi = pair_b + 16'h0001;
					s_d.word = 1'b0;
					s_d.prog = ~OP_CODE[0];
					s_d.dprog = ~OP_CODE[1];
					s_d.dst = pair_a;
					s_d.stb = 1'b1;
					s_d.st = ST_READ;
					s_d.rf = put_pair(s_d.rf, ah_b, al_b, pair_b + 16'h0001);
					s_d.rf = put_pair(s_d.rf, ah_a, al_a, pair_a + 16'h0001);
				end
				wait_for_interrupt_op: s_d.st = ST_WAIT;
				halt_op: s_d.st = ST_HALT;
				set_long_reg_pointer_op: begin
					s_d.rp0 = {OP_IMM[7:4], 4'h0};
					s_d.rp1 = {OP_IMM[7:4], 4'h8};
				end
				set_low_reg_pointer_op: s_d.rp0 = {OP_IMM[7:3], 3'h0};
				set_high_reg_pointer_op: s_d.rp1 = {OP_IMM[7:3], 3'h0};
				select_prog_space_op: s_d.flags[FB_DP] = 1'b0;
				select_data_space_op: s_d.flags[FB_DP] = 1'b1;
				jump_cond_op: s_d.branch = cond_met(s_q.flags, OP_IMM[3:0]);
				decrement_reg_branch_op: begin
					s_d.rf[wb_adr] = wr - 8'h01;
					s_d.branch = wr != 8'h01;
				end
				decrement_pair_branch_op: begin
					s_d.rf = put_pair(s_d.rf, ah_a, al_a, pair_a - 16'h0001);
					s_d.branch = pair_a != 16'h0001;
				end
				multiply_byte_op: begin
					q = pair_a[7:0] * wr;
					s_d.rf = put_pair(s_d.rf, ah_a, al_a, q);
					s_d.flags[FB_Z] = q == 16'h0000;
				end
				divide_byte_op: begin
					if (wr == 8'h00) begin
						s_d.flags[FB_V] = 1'b1;
					end else begin
						q = pair_a / {8'h00, wr};
						pv = pair_a % {8'h00, wr};
						s_d.flags[FB_V] = q[15:8] != 8'h00;
						s_d.rf = put_pair(s_d.rf, ah_a, al_a, {pv[7:0], q[7:0]});
					end
				end
				stepped_long_divide_op: begin
					sh = {pair_a, pair_b, 1'b0};
					hit = sh[32:16] >= {1'b0, OP_IMM};
					if (hit) begin
						sh[32:16] = sh[32:16] - {1'b0, OP_IMM};
						sh[0] = 1'b1;
					end
					s_d.flags[FB_C] = hit;
					s_d.rf = put_pair(s_d.rf, ah_a, al_a, sh[31:16]);
					s_d.rf = put_pair(s_d.rf, ah_b, al_b, sh[15:0]);
				end
				default: s_d.illegal = OP_CODE >= OPC_W'(NUM_OP_TYPES);
				endcase
			end
		end
		ST_READ: begin
			s_d.st = ST_IDLE;
			case (s_q.op)
			bit_test_set_op: begin
				s_d.flags[FB_Z] = ~MEM_RDATA[s_q.bitn];
				s_d.wdata = {8'h00, MEM_RDATA[7:0] | (8'h01 << s_q.bitn)};
				s_d.stb = 1'b1;
				s_d.we = 1'b1;
			end
			compare_jump_false_op, compare_jump_true_op: begin
				hit = MEM_RDATA[7:0] == s_q.cmp;
				s_d.branch = (s_q.op == compare_jump_true_op) ? hit : !hit;
				if (!s_d.branch) begin
					s_d.rf = put_pair(s_d.rf, wra({s_q.sv_a, 1'b0}, s_q.rp0,
						s_q.rp1), wra({s_q.sv_a, 1'b1}, s_q.rp0, s_q.rp1),
						s_q.addr + 16'h0001);
				end
			end
			load_prog_to_prog_op, load_data_to_prog_op,
			load_prog_to_data_op, load_data_to_data_op: begin
				s_d.addr = s_q.dst;
				s_d.addr_hi = s_q.dst + 16'h0001;
				s_d.prog = s_q.dprog;
				s_d.wdata = {8'h00, MEM_RDATA[7:0]};
				s_d.stb = 1'b1;
				s_d.we = 1'b1;
			end
			default: s_d.result = s_q.word ? MEM_RDATA : {8'h00, MEM_RDATA[7:0]};
			endcase
		end
		ST_WAIT: begin
			if (s_q.dma_s2) begin
				s_d.st = ST_DMA;
			end else if (s_q.irq_s2) begin
				s_d.st = ST_IDLE;
			end
		end
		ST_DMA: begin
			s_d.dma_ack = 1'b1;
			s_d.st = ST_WAIT;
		end
		ST_HALT: s_d.st = ST_HALT;
		default: s_d.st = ST_IDLE;
		endcase
		s_d.busy = s_d.st != ST_IDLE;
		s_d.halted = s_d.st == ST_HALT;
		s_d.waiting = s_d.st == ST_WAIT;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			s_q <= '0;
		end else if (CE) begin
			s_q <= s_d;
		end
	end

	assign RF_RDATA = s_q.rdo;
	assign MEM_ADDR = s_q.addr;
	assign MEM_ADDR_NEXT = s_q.addr_hi;
	assign MEM_WORD = s_q.word;
	assign MEM_PROG = s_q.prog;
	assign MEM_STB = s_q.stb;
	assign MEM_WE = s_q.we;
	assign MEM_WDATA = s_q.wdata;
	assign RESULT = s_q.result;
	assign FLAGS = s_q.flags;
	assign RP_LOW = s_q.rp0;
	assign RP_HIGH = s_q.rp1;
	assign BRANCH = s_q.branch;
	assign DMA_ACK = s_q.dma_ack;
	assign BUSY = s_q.busy;
	assign HALTED = s_q.halted;
	assign WAITING = s_q.waiting;
	assign ILLEGAL = s_q.illegal;

	// ==============================
	// Assertions
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	sequence bt_start;
		acc && OP_CODE == bit_test_set_op ##1 CE;
	endsequence

	space_select_a: assert property (acc && OP_CODE == mem_read_op
		|=> MEM_STB && MEM_PROG == !$past(FLAGS[FB_DP]))
		else $error("access in wrong space");
	word_pair_a: assert property (MEM_STB
		|-> MEM_ADDR_NEXT == MEM_ADDR + 16'h0001)
		else $error("word pair address wrong");
	post_inc_a: assert property (acc && OP_CODE == mem_read_op &&
		OP_MODE == AM_POSTINC |=> MEM_ADDR == $past(pair_a))
		else $error("post-increment used updated pointer");
	pre_dec_a: assert property (acc && OP_CODE == mem_read_op &&
		OP_MODE == AM_PREDEC && !OP_WORD
		|=> MEM_ADDR == $past(pair_a) - 16'h0001)
		else $error("pre-decrement address wrong");
	short_index_a: assert property (acc && OP_CODE == mem_write_op &&
		OP_MODE == AM_SHORT |=> MEM_ADDR == $past(pair_a) +
		{{8{$past(OP_IMM[7])}}, $past(OP_IMM[7:0])})
		else $error("short index not sign-extended");
	btset_write_a: assert property (bt_start
		|=> MEM_STB && MEM_WE && MEM_WDATA[$past(OP_IMM[2:0], 2)])
		else $error("bit test-and-set did not write bit");
	halt_sticky_a: assert property (acc && OP_CODE == halt_op
		|=> HALTED ##1 HALTED [*3])
		else $error("halt left before reset");
	dma_return_a: assert property (s_q.st == ST_DMA && CE
		|=> DMA_ACK && WAITING)
		else $error("dma service did not return to wait");
	cond_zero_a: assert property (acc && OP_CODE == jump_cond_op &&
		OP_IMM[3:0] == 4'h6 |=> BRANCH == $past(FLAGS[FB_Z]))
		else $error("zero condition mis-decoded");
	flag_read_a: assert property (CE && RF_ADDR == FLAG_REG_ADDR &&
		!RF_WE |=> RF_RDATA == $past(FLAGS))
		else $error("flag register read wrong");
endmodule : ocpu_core
`default_nettype wire

// ### hdl/ocpu_pkg.sv
package ocpu_pkg;
	// ==============================
	// Address spaces and flag register
	localparam int ADDR_W = 16;
	localparam logic [7:0] FLAG_REG_ADDR = 8'he7;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam int FB_C = 7;
	localparam int FB_Z = 6;
	localparam int FB_S = 5;
	localparam int FB_V = 4;
	localparam int FB_D = 3;
	localparam int FB_H = 2;
	localparam int FB_USER = 1;
	localparam int FB_DP = 0;
	// ==============================
	// Operation codes
	localparam int NUM_OP_TYPES = 87;
	localparam int OPC_W = 7;
	localparam logic [6:0] mem_read_op = 7'h01;
	localparam logic [6:0] mem_write_op = 7'h02;
	localparam logic [6:0] bit_test_set_op = 7'h03;
	localparam logic [6:0] wait_for_interrupt_op = 7'h04;
	localparam logic [6:0] halt_op = 7'h05;
	localparam logic [6:0] set_long_reg_pointer_op = 7'h06;
	localparam logic [6:0] set_low_reg_pointer_op = 7'h07;
	localparam logic [6:0] set_high_reg_pointer_op = 7'h08;
	localparam logic [6:0] select_prog_space_op = 7'h09;
	localparam logic [6:0] select_data_space_op = 7'h0a;
	localparam logic [6:0] jump_cond_op = 7'h0b;
	localparam logic [6:0] decrement_reg_branch_op = 7'h0c;
	localparam logic [6:0] decrement_pair_branch_op = 7'h0d;
	localparam logic [6:0] compare_jump_false_op = 7'h0e;
	localparam logic [6:0] compare_jump_true_op = 7'h0f;
	localparam logic [6:0] load_prog_to_prog_op = 7'h10;
	localparam logic [6:0] load_data_to_prog_op = 7'h11;
	localparam logic [6:0] load_prog_to_data_op = 7'h12;
	localparam logic [6:0] load_data_to_data_op = 7'h13;
	localparam logic [6:0] multiply_byte_op = 7'h14;
	localparam logic [6:0] divide_byte_op = 7'h15;
	localparam logic [6:0] stepped_long_divide_op = 7'h16;
	// ==============================
	// Memory addressing modes
	localparam logic [2:0] AM_DIRECT = 3'h0;
	localparam logic [2:0] AM_IND = 3'h1;
	localparam logic [2:0] AM_POSTINC = 3'h2;
	localparam logic [2:0] AM_PREDEC = 3'h3;
	localparam logic [2:0] AM_SHORT = 3'h4;
	localparam logic [2:0] AM_LONG = 3'h5;
	localparam logic [2:0] AM_REGIDX = 3'h6;
	// ==============================
	// State
	typedef enum logic [2:0] {
		ST_IDLE, ST_READ, ST_WAIT, ST_DMA, ST_HALT
	} ocpu_state_t;
	typedef struct packed {
		ocpu_state_t st;
		logic [255:0][7:0] rf;
		logic [7:0] flags, rp0, rp1, rdo, cmp;
		logic irq_s1, irq_s2, dma_s1, dma_s2;
		logic [15:0] addr, addr_hi, wdata, result, dst;
		logic word, prog, stb, we, branch, dma_ack, illegal;
		logic busy, halted, waiting, dprog;
		logic [6:0] op;
		logic [2:0] bitn, sv_a;
	} ocpu_s_t;
endpackage : ocpu_pkg

// ### tb/ocpu_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ocpu_mem (
	input wire logic REF_CLK,
	input wire logic [15:0] MEM_ADDR,
	input wire logic [15:0] MEM_ADDR_NEXT,
	input wire logic MEM_WORD,
	input wire logic MEM_PROG,
	input wire logic MEM_STB,
	input wire logic MEM_WE,
	input wire logic [15:0] MEM_WDATA,
	output logic [15:0] MEM_RDATA
);
	// ==========
	// Program and data spaces of 64K bytes each, picked by the space line.
	logic [7:0] m [0:131071];
	logic [15:0] last_q = 16'h0000;
	logic rd;
	assign rd = MEM_STB && !MEM_WE;
	// Outside a read the data lines show the inverse of the last word.
	assign MEM_RDATA = rd ? {m[{MEM_PROG, MEM_ADDR_NEXT}],
		m[{MEM_PROG, MEM_ADDR}]} : ~last_q;
	always @(posedge REF_CLK) begin
		if (rd)
			last_q <= MEM_RDATA;
		if (MEM_STB && MEM_WE) begin
			m[{MEM_PROG, MEM_ADDR}] <= MEM_WDATA[7:0];
			if (MEM_WORD)
				m[{MEM_PROG, MEM_ADDR_NEXT}] <= MEM_WDATA[15:8];
		end
	end
endmodule : ocpu_mem
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import ocpu_pkg::*;
;
	logic REF_CLK, RSTN = 0, CE = 1, RF_WE = 0, OP_VALID = 0, OP_WORD = 0;
	logic IRQ_PIN = 0, DMA_REQ_PIN = 0;
	logic [7:0] RF_ADDR = 0, RF_WDATA = 0, RF_RDATA, FLAGS, RP_LOW, RP_HIGH;
	logic [6:0] OP_CODE = 0;
	logic [2:0] OP_MODE = 0;
	logic [3:0] OP_PA = 0, OP_PB = 0;
	logic [15:0] OP_IMM = 0, MEM_RDATA, MEM_ADDR, MEM_ADDR_NEXT;
	logic [15:0] MEM_WDATA, RESULT, s_addr, s_nxt;
	logic MEM_WORD, MEM_PROG, MEM_STB, MEM_WE, BRANCH, DMA_ACK, BUSY;
	logic HALTED, WAITING, ILLEGAL, s_prog, s_word;
	int fails = 0, samples_checked = 0, cyc = 0;
	int stb_n = 0, br_n = 0, il_n = 0, ack_n = 0;
	ocpu_core dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .CE(CE),
		.RF_ADDR(RF_ADDR), .RF_WE(RF_WE), .RF_WDATA(RF_WDATA),
		.RF_RDATA(RF_RDATA), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
		.OP_MODE(OP_MODE), .OP_WORD(OP_WORD), .OP_PA(OP_PA), .OP_PB(OP_PB),
		.OP_IMM(OP_IMM), .IRQ_PIN(IRQ_PIN), .DMA_REQ_PIN(DMA_REQ_PIN),
		.MEM_RDATA(MEM_RDATA), .MEM_ADDR(MEM_ADDR),
		.MEM_ADDR_NEXT(MEM_ADDR_NEXT), .MEM_WORD(MEM_WORD),
		.MEM_PROG(MEM_PROG), .MEM_STB(MEM_STB), .MEM_WE(MEM_WE),
		.MEM_WDATA(MEM_WDATA), .RESULT(RESULT), .FLAGS(FLAGS),
		.RP_LOW(RP_LOW), .RP_HIGH(RP_HIGH), .BRANCH(BRANCH),
		.DMA_ACK(DMA_ACK), .BUSY(BUSY), .HALTED(HALTED),
		.WAITING(WAITING), .ILLEGAL(ILLEGAL));
	ocpu_mem mem (.REF_CLK(REF_CLK), .MEM_ADDR(MEM_ADDR),
		.MEM_ADDR_NEXT(MEM_ADDR_NEXT), .MEM_WORD(MEM_WORD),
		.MEM_PROG(MEM_PROG), .MEM_STB(MEM_STB), .MEM_WE(MEM_WE),
		.MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA));
	// ==========
	// Clock, monitor of strobes and pulses, hang guard.
	initial begin
		REF_CLK = 0;
		forever #10 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK) begin
		if (MEM_STB === 1'b1) begin
			stb_n++;
			s_addr = MEM_ADDR;
			s_nxt = MEM_ADDR_NEXT;
			s_prog = MEM_PROG;
			s_word = MEM_WORD;
		end
		br_n += int'(BRANCH === 1'b1);
		il_n += int'(ILLEGAL === 1'b1);
		ack_n += int'(DMA_ACK === 1'b1);
		cyc++;
		if (cyc == 5000) begin
			fails++;
			test_done;
		end
	end
	// ==========
	// Shared tasks.
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
		samples_checked++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, s);
			fails++;
		end
	endtask : chk
	task automatic rfw(logic [7:0] a, logic [7:0] d);
		@(posedge REF_CLK);
		RF_ADDR <= a;
		RF_WDATA <= d;
		RF_WE <= 1'b1;
		@(posedge REF_CLK);
		RF_WE <= 1'b0;
	endtask : rfw
	task automatic rdr(logic [7:0] a, output logic [7:0] d);
		@(posedge REF_CLK);
		RF_ADDR <= a;
		repeat (2) @(posedge REF_CLK);
		#1 d = RF_RDATA;
	endtask : rdr
	// Pair n lives at working registers n (high) and n+1 (low).
	task automatic setp(logic [3:0] n, logic [15:0] v);
		rfw({4'h2, n}, v[15:8]);
		rfw({4'h2, n[3:1], 1'b1}, v[7:0]);
	endtask : setp
	task automatic pchk(string nm, logic [3:0] n, logic [15:0] e);
		logic [15:0] v;
		rdr({4'h2, n}, v[15:8]);
		rdr({4'h2, n[3:1], 1'b1}, v[7:0]);
		chk(nm, e, v);
	endtask : pchk
	task automatic op(logic [6:0] c, logic [2:0] md, logic w, logic [3:0] a,
		logic [3:0] b, logic [15:0] im);
		int n = 0;
		@(posedge REF_CLK);
		OP_VALID <= 1'b1;
		OP_CODE <= c;
		OP_MODE <= md;
		OP_WORD <= w;
		OP_PA <= a;
		OP_PB <= b;
		OP_IMM <= im;
		@(posedge REF_CLK);
		OP_VALID <= 1'b0;
		@(posedge REF_CLK);
		while (BUSY === 1'b1 && n < 20) begin
			@(posedge REF_CLK);
			n++;
		end
		@(posedge REF_CLK);
		#1;
	endtask : op
	task automatic am(logic [2:0] md, logic w, logic [3:0] a, logic [3:0] b,
		logic [15:0] im, av, bv, ea, ep);
		setp(b, bv);
		setp(a, av);
		op(mem_write_op, md, w, a, b, im);
		chk("mem_addr", ea, s_addr);
		chk("mem_addr_next", ea + 16'h0001, s_nxt);
		chk("mem_word", {15'h0, w}, {15'h0, s_word});
		chk("mem_prog", 16'h0001, {15'h0, s_prog});
		pchk("pair_after", a, ep);
	endtask : am
	// ==========
	// Scenarios.
	task automatic t_modes;
		op(set_long_reg_pointer_op, 3'h0, 1'b0, 4'h0, 4'h0, 16'h0020);
		chk("rp_low", 16'h0020, {8'h00, RP_LOW});
		chk("rp_high", 16'h0028, {8'h00, RP_HIGH});
		am(AM_DIRECT, 0, 8, 14, 16'h3042, 16'h07d0, 0, 16'h3042, 16'h07d0);
		am(AM_IND, 0, 8, 14, 0, 16'h07d0, 0, 16'h07d0, 16'h07d0);
		am(AM_POSTINC, 1, 4, 14, 0, 16'h0bb8, 0, 16'h0bb8, 16'h0bba);
		am(AM_PREDEC, 0, 6, 14, 0, 16'h0457, 0, 16'h0456, 16'h0456);
		am(AM_SHORT, 0, 6, 14, 16'h00fe, 16'h1f40, 0, 16'h1f3e, 16'h1f40);
		am(AM_LONG, 0, 2, 14, 16'h0142, 16'h07d0, 0, 16'h0912, 16'h07d0);
		am(AM_REGIDX, 0, 0, 4, 0, 16'h08ae, 16'h0d05, 16'h15b3, 16'h08ae);
		am(AM_POSTINC, 0, 12, 14, 0, 16'hffff, 0, 16'hffff, 16'h0000);
	endtask : t_modes
	task automatic t_space;
		rfw(FLAG_REG_ADDR, 8'h02);
		@(posedge REF_CLK);
		#1 chk("flag_reg", 16'h0002, {8'h00, FLAGS});
		op(select_data_space_op, 3'h0, 1'b0, 4'h0, 4'h0, 16'h0000);
		chk("dp_bit", 16'h0003, {8'h00, FLAGS});
		mem.m[17'h03042] = 8'h5a;
		op(mem_read_op, AM_DIRECT, 1'b0, 4'h0, 4'h0, 16'h3042);
		chk("read_data", 16'h005a, {8'h00, RESULT[7:0]});
		chk("data_space", 16'h0000, {15'h0, s_prog});
	endtask : t_space
	task automatic t_btset;
		setp(8, 16'h07d0);
		mem.m[17'h007d0] = 8'h01;
		op(bit_test_set_op, 3'h0, 1'b0, 4'h8, 4'h0, 16'h0003);
		chk("btset_byte", 16'h0009, {8'h00, mem.m[17'h007d0]});
		chk("btset_z1", 16'h0001, {15'h0, FLAGS[FB_Z]});
		op(bit_test_set_op, 3'h0, 1'b0, 4'h8, 4'h0, 16'h0003);
		chk("btset_z0", 16'h0000, {15'h0, FLAGS[FB_Z]});
	endtask : t_btset
	task automatic t_xload;
		mem.m[17'h00100] = 8'ha5;
		setp(4, 16'h0100);
		setp(2, 16'h0200);
		op(load_data_to_prog_op, 3'h0, 1'b0, 4'h2, 4'h4, 16'h0000);
		chk("xload", 16'h00a5, {8'h00, mem.m[17'h10200]});
		chk("xload_dp", 16'h0001, {15'h0, FLAGS[FB_DP]});
		pchk("xload_src", 4, 16'h0101);
		pchk("xload_dst", 2, 16'h0201);
	endtask : t_xload
	task automatic t_decrement_pair_branch_op;
		int b0 = br_n;
		setp(10, 16'h0002);
		op(decrement_pair_branch_op, 3'h0, 1'b0, 4'ha, 4'h0, 16'h0000);
		chk("branch_taken", 16'h0001, 16'(br_n - b0));
		op(decrement_pair_branch_op, 3'h0, 1'b0, 4'ha, 4'h0, 16'h0000);
		chk("branch_zero", 16'h0001, 16'(br_n - b0));
		pchk("dec_pair", 10, 16'h0000);
	endtask : t_decrement_pair_branch_op
	task automatic t_misc;
		int b0 = br_n;
		op(jump_cond_op, 3'h0, 1'b0, 4'h0, 4'h0, 16'h0006);
		chk("jump_z", 16'h0000, 16'(br_n - b0));
		op(jump_cond_op, 3'h0, 1'b0, 4'h0, 4'h0, 16'h000e);
		chk("jump_nz", 16'h0001, 16'(br_n - b0));
		rfw(8'h2e, 8'h09);
		op(compare_jump_true_op, 3'h0, 1'b0, 4'h8, 4'he, 16'h0000);
		chk("cmp_true", 16'h0002, 16'(br_n - b0));
		pchk("cmp_true_ptr", 8, 16'h07d0);
		op(compare_jump_false_op, 3'h0, 1'b0, 4'h8, 4'he, 16'h0000);
		chk("cmp_false", 16'h0002, 16'(br_n - b0));
		pchk("cmp_false_ptr", 8, 16'h07d1);
		op(multiply_byte_op, 3'h0, 1'b0, 4'h0, 4'he, 16'h0000);
		pchk("mul_result", 0, 16'h061e);
	endtask : t_misc
	task automatic t_illegal;
		op(7'h56, 3'h0, 1'b0, 4'h0, 4'h0, 16'h0000);
		chk("last_legal", 16'h0000, 16'(il_n));
		op(7'h57, 3'h0, 1'b0, 4'h0, 4'h0, 16'h0000);
		chk("first_illegal", 16'h0001, 16'(il_n));
	endtask : t_illegal
	task automatic t_wait;
		int n = 0;
		op(wait_for_interrupt_op, 3'h0, 1'b0, 4'h0, 4'h0, 16'h0000);
		chk("waiting", 16'h0001, {15'h0, WAITING});
		@(posedge REF_CLK);
		DMA_REQ_PIN <= 1'b1;
		while (ack_n == 0 && n < 20) begin
			@(posedge REF_CLK);
			n++;
		end
		DMA_REQ_PIN <= 1'b0;
		repeat (8) @(posedge REF_CLK);
		#1 chk("dma_ack", 16'h0001, {15'h0, ack_n != 0});
		chk("back_waiting", 16'h0001, {15'h0, WAITING});
		@(posedge REF_CLK);
		IRQ_PIN <= 1'b1;
		repeat (5) @(posedge REF_CLK);
		#1 chk("woken", 16'h0000, {15'h0, WAITING});
		@(posedge REF_CLK);
		IRQ_PIN <= 1'b0;
	endtask : t_wait
	task automatic t_halt;
		int s0;
		op(halt_op, 3'h0, 1'b0, 4'h0, 4'h0, 16'h0000);
		chk("halted", 16'h0001, {15'h0, HALTED});
		s0 = stb_n;
		op(mem_write_op, AM_DIRECT, 1'b0, 4'h0, 4'h0, 16'h0040);
		chk("no_access", 16'h0000, 16'(stb_n - s0));
		@(posedge REF_CLK);
		RSTN <= 1'b0;
		@(posedge REF_CLK);
		RSTN <= 1'b1;
		@(posedge REF_CLK);
		#1 chk("resumed", 16'h0000, {15'h0, HALTED});
		chk("flags_rst", 16'h0000, {8'h00, FLAGS});
	endtask : t_halt
	initial begin
		repeat (12) @(posedge REF_CLK);
		RSTN <= 1'b1;
		@(posedge REF_CLK);
		#1 chk("flags_init", 16'h0000, {8'h00, FLAGS});
		t_modes;
		t_space;
		t_btset;
		t_xload;
		t_decrement_pair_branch_op;
		t_misc;
		t_illegal;
		t_wait;
		t_halt;
		test_done;
	end
endmodule : testbench
`default_nettype wire
